// ==== event_time_stamp_capture.sv ====
// Summary of operation
// - event and time counters are 32 bits, two cascaded 16-bit stages each
// - channel A or B source counts one per qualified trigger edge
// - channel C passes a divide-by-four prescaler before counting
// - time counter runs free every timebase tick, 2 ns per step
// - interpolator offset to next timebase edge is kept with each sample
// - event count is latched at the event and written to capture memory at the tick
// - time count is copied at the first timebase tick after the event
// - captured samples are moved out and sent as raw binary
// - above the timing rate, events may go untimed but stay counted
// - output is bytes, most significant byte first
// - transmission opens with hash, six, and six length digits
`timescale 1ns/1ps
`default_nettype none
module event_time_stamp_capture #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // input channels and qualification
  input wire logic chan_a,
  input wire logic chan_b,
  input wire logic chan_c,
  input wire logic [1:0] src_sel,
  input wire logic armed,
  // timebase tick and interpolator from analog front end
  input wire logic tb_tick,
  input wire logic [capture_pkg::INTERP_W-1:0] interp_in,
  // output request and byte stream
  input wire logic send_req,
  input wire logic byte_ready,
  output logic [7:0] byte_data_ff,
  output logic byte_valid_ff,
  output logic busy_ff
);
  // ==========================================================
  // input synchronisers
  logic [2:0] s1_ff, s2_ff, s3_ff;
  logic arm1_ff, arm2_ff, tb1_ff, tb2_ff, tb3_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      arm1_ff <= 1'b0;
      arm2_ff <= 1'b0;
      tb1_ff <= 1'b0;
      tb2_ff <= 1'b0;
      tb3_ff <= 1'b0;
    end else begin
      s1_ff <= {chan_c, chan_b, chan_a};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      arm1_ff <= armed;
      arm2_ff <= arm1_ff;
      tb1_ff <= tb_tick;
      tb2_ff <= tb1_ff;
      tb3_ff <= tb2_ff;
    end
  end
  logic [2:0] rise;
  logic tb_edge;
  assign rise = s2_ff & ~s3_ff;
  assign tb_edge = tb2_ff & ~tb3_ff;
  // ==========================================================
  // event qualification
  logic [1:0] presc_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      presc_ff <= '0;
    end else if (rise[2]) begin
      presc_ff <= presc_ff + 2'h1;
    end
  end
  logic raw_hit;
  always_comb begin
    unique case (src_sel)
      capture_pkg::SRC_A: raw_hit = rise[0];
      capture_pkg::SRC_B: raw_hit = rise[1];
      capture_pkg::SRC_C: raw_hit = rise[2] && (presc_ff == capture_pkg::PRESCALE_LAST);
      default: raw_hit = 1'b0;
    endcase
  end
  logic event_pulse;
  assign event_pulse = raw_hit && arm2_ff;
  // ==========================================================
  // counters
  logic [capture_pkg::CNT_W-1:0] event_cnt, time_cnt;
  cascade_counter #(.HALF(capture_pkg::HALF_W)) u_event_cnt (
    .clk_sys(clk_sys),
    .rst(rst),
    .inc(event_pulse),
    .value(event_cnt)
  );
  cascade_counter #(.HALF(capture_pkg::HALF_W)) u_time_cnt (
    .clk_sys(clk_sys),
    .rst(rst),
    .inc(tb_edge),
    .value(time_cnt)
  );
  // ==========================================================
  // capture: event count now, time count at next tick
  logic pend_ff;
  logic [3:0] gap_ff;
  logic [capture_pkg::CNT_W-1:0] ev_hold_ff;
  logic [capture_pkg::INTERP_W-1:0] ip_hold_ff;
  logic timed;
  logic mem_wr;
  assign timed = event_pulse && !pend_ff && (gap_ff == 4'h0);
  assign mem_wr = pend_ff && tb_edge;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_ff <= 1'b0;
      ev_hold_ff <= '0;
      ip_hold_ff <= '0;
    end else if (timed) begin
      pend_ff <= 1'b1;
      ev_hold_ff <= event_cnt + 1'b1;
      ip_hold_ff <= interp_in;
    end else if (mem_wr) begin
      pend_ff <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap_ff <= 4'h0;
    end else if (timed) begin
      gap_ff <= capture_pkg::MIN_SPACING_CYC - 4'h1;
    end else if (gap_ff != 4'h0) begin
      gap_ff <= gap_ff - 4'h1;
    end
  end
  capture_pkg::sample_t mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic [AW:0] fill_ff;
  logic rd_take;
  logic mem_push;
  assign mem_push = mem_wr && (fill_ff < AW'(DEPTH - 1) + 1);
  always_ff @(posedge clk_sys) begin
    if (mem_push) begin
      mem[wr_ptr_ff] <= '{event_cnt: ev_hold_ff, time_cnt: time_cnt + 1'b1,
                          interp: ip_hold_ff};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_ff <= '0;
    end else if (mem_push) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fill_ff <= '0;
    end else begin
      fill_ff <= fill_ff + (mem_push ? 1'b1 : 1'b0) - (rd_take ? 1'b1 : 1'b0);
    end
  end
  // ==========================================================
  // transmitter
  capture_pkg::tx_state_t st_ff;
  logic [AW:0] n_ff;
  logic [3:0] idx_ff;
  logic [2:0] dig_ff;
  logic [19:0] len_ff;
  logic [19:0] len_div;
  capture_pkg::sample_t cur_ff;
  logic byte_done;
  assign byte_done = byte_valid_ff && byte_ready;
  assign rd_take = (st_ff == capture_pkg::TX_DATA) && byte_done &&
                   (idx_ff == 4'(capture_pkg::SAMPLE_BYTES - 1));
  function automatic logic [19:0] pow10(input logic [2:0] d);
    unique case (d)
      3'h0: pow10 = 20'd100000;
      3'h1: pow10 = 20'd10000;
      3'h2: pow10 = 20'd1000;
      3'h3: pow10 = 20'd100;
      3'h4: pow10 = 20'd10;
      default: pow10 = 20'd1;
    endcase
  endfunction : pow10
  assign len_div = len_ff / pow10(dig_ff);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= capture_pkg::TX_IDLE;
      byte_valid_ff <= 1'b0;
      byte_data_ff <= 8'h00;
      busy_ff <= 1'b0;
      n_ff <= '0;
      idx_ff <= 4'h0;
      dig_ff <= 3'h0;
      len_ff <= '0;
      cur_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      unique case (st_ff)
        capture_pkg::TX_IDLE: begin
          if (send_req && fill_ff != 0) begin
            n_ff <= fill_ff;
            len_ff <= 20'(fill_ff) * 20'(capture_pkg::SAMPLE_BYTES);
            dig_ff <= 3'h0;
            byte_data_ff <= capture_pkg::HDR_HASH;
            byte_valid_ff <= 1'b1;
            busy_ff <= 1'b1;
            st_ff <= capture_pkg::TX_HASH;
          end
        end
        capture_pkg::TX_HASH: if (byte_done) begin
          byte_data_ff <= capture_pkg::HDR_SIX;
          st_ff <= capture_pkg::TX_SIX;
        end
        capture_pkg::TX_SIX: if (byte_done) begin
          byte_data_ff <= capture_pkg::ASCII_ZERO + 8'(len_div % 10);
          dig_ff <= 3'h1;
          st_ff <= capture_pkg::TX_LEN;
        end
        capture_pkg::TX_LEN: if (byte_done) begin
          if (dig_ff == 3'(capture_pkg::HDR_DIGITS)) begin
            cur_ff <= mem[rd_ptr_ff];
            byte_data_ff <= mem[rd_ptr_ff][71:64];
            idx_ff <= 4'h0;
            st_ff <= capture_pkg::TX_DATA;
          end else begin
            byte_data_ff <= capture_pkg::ASCII_ZERO + 8'(len_div % 10);
            dig_ff <= dig_ff + 3'h1;
          end
        end
        capture_pkg::TX_DATA: if (byte_done) begin
          if (idx_ff == 4'(capture_pkg::SAMPLE_BYTES - 1)) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
            if (n_ff == 1) begin
              byte_valid_ff <= 1'b0;
              busy_ff <= 1'b0;
              st_ff <= capture_pkg::TX_IDLE;
            end else begin
              n_ff <= n_ff - 1'b1;
              cur_ff <= mem[rd_ptr_ff + 1'b1];
              byte_data_ff <= mem[rd_ptr_ff + 1'b1][71:64];
              idx_ff <= 4'h0;
            end
          end else begin
            byte_data_ff <= 8'(cur_ff << (8 * (idx_ff + 1)) >> 64);
            idx_ff <= idx_ff + 4'h1;
          end
        end
        default: st_ff <= capture_pkg::TX_IDLE;
      endcase
    end
  end
  // ==========================================================
  // checks
  chk_event_count: assert property (@(posedge clk_sys) disable iff (rst)
    event_pulse |=> event_cnt == $past(event_cnt) + 1) else $error("event not counted");
  chk_no_arm: assert property (@(posedge clk_sys) disable iff (rst)
    !arm2_ff |=> event_cnt == $past(event_cnt)) else $error("count while disarmed");
  chk_time_run: assert property (@(posedge clk_sys) disable iff (rst)
    tb_edge |=> time_cnt == $past(time_cnt) + 1) else $error("time counter stalled");
  chk_wrap_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (tb_edge && &time_cnt) |=> time_cnt == 0) else $error("time counter no wrap");
  chk_ev_latch: assert property (@(posedge clk_sys) disable iff (rst)
    timed |=> ev_hold_ff == event_cnt) else $error("event count not latched");
  chk_pend_close: assert property (@(posedge clk_sys) disable iff (rst)
    (pend_ff && tb_edge) |=> !pend_ff) else $error("time capture missed");
  chk_hdr_six: assert property (@(posedge clk_sys) disable iff (rst)
    (st_ff == capture_pkg::TX_HASH && byte_done) |=> byte_data_ff == 8'h36)
    else $error("header six missing");
  chk_fill_bound: assert property (@(posedge clk_sys) disable iff (rst)
    fill_ff <= DEPTH) else $error("capture memory overrun");
  chk_c_prescale: assert property (@(posedge clk_sys) disable iff (rst)
    (src_sel == capture_pkg::SRC_C && rise[2] && presc_ff != 2'h3) |=> !$past(event_pulse))
    else $error("prescaler bypassed");
  cov_timed: cover property (@(posedge clk_sys) disable iff (rst) timed ##[1:40] mem_wr);
  cov_skip: cover property (@(posedge clk_sys) disable iff (rst) event_pulse && !timed);
  cov_send: cover property (@(posedge clk_sys) disable iff (rst) rd_take);
endmodule : event_time_stamp_capture
`default_nettype wire

// ==== capture_pkg.sv ====
`default_nettype none
package capture_pkg;
  localparam int CNT_W = 32;
  localparam int HALF_W = 16;
  localparam int INTERP_W = 8;
  localparam int BYTE_W = 8;
  localparam logic [1:0] SRC_A = 2'h0;
  localparam logic [1:0] SRC_B = 2'h1;
  localparam logic [1:0] SRC_C = 2'h2;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [7:0] HDR_HASH = 8'h23;
  localparam logic [7:0] HDR_SIX = 8'h36;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam int HDR_DIGITS = 6;
  localparam int SAMPLE_BYTES = 9;
  localparam int CLK_MHZ = 40;
  localparam int TIMEBASE_MHZ = 500;
  localparam int RATE_LIMIT_MHZ = 10;
  localparam int MIN_SPACING = (CLK_MHZ + RATE_LIMIT_MHZ - 1) / RATE_LIMIT_MHZ;
  localparam logic [3:0] MIN_SPACING_CYC = MIN_SPACING[3:0];
  typedef struct packed {
    logic [CNT_W-1:0] event_cnt;
    logic [CNT_W-1:0] time_cnt;
    logic [INTERP_W-1:0] interp;
  } sample_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_HASH = 3'b001,
    TX_SIX = 3'b010,
    TX_LEN = 3'b011,
    TX_DATA = 3'b100
  } tx_state_t;
endpackage : capture_pkg
`default_nettype wire

// ==== cascade_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module cascade_counter #(
  parameter int HALF = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // count control
  input wire logic inc,
  output logic [2*HALF-1:0] value
);
  logic [HALF-1:0] low_ff;
  logic [HALF-1:0] high_ff;
  // low stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_ff <= '0;
    end else if (inc) begin
      low_ff <= low_ff + 1'b1;
    end
  end
  // high stage carries on low stage terminal count, wraps silently
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      high_ff <= '0;
    end else if (inc && (&low_ff)) begin
      high_ff <= high_ff + 1'b1;
    end
  end
  assign value = {high_ff, low_ff};
endmodule : cascade_counter
`default_nettype wire

// ==== host_byte_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// host side byte sink
module host_byte_sink (
  // clock
  input wire logic clk_sys,
  // byte stream from the device
  input wire logic [7:0] byte_data,
  input wire logic byte_valid,
  // stall control
  input wire logic slow,
  output logic byte_ready
);
  logic [7:0] rx_q[$];
  initial byte_ready = 1'b0;
  // a byte moves only on an edge where valid and ready are both high
  always @(posedge clk_sys) begin
    if (byte_valid === 1'b1 && byte_ready === 1'b1) begin
      rx_q.push_back(byte_data);
    end
    byte_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  end
  // ==========
  // host rebuild of event stamps, time stamps and frequency from one frame
  localparam int HDR_BYTES = 8;
  localparam int SAMPLE_LEN = 9;
  localparam longint TICK_PS = 2000;
  localparam longint INTERP_PS = 200;
  localparam longint PS_PER_S = 64'sd1000000000000;
  longint ev_stamp_q[$];
  longint time_ps_q[$];
  task automatic rebuild();
    longint ev_wrap;
    longint tm_wrap;
    logic [31:0] ev_raw;
    logic [31:0] tm_raw;
    logic [31:0] ev_last;
    logic [31:0] tm_last;
    int base;
    ev_wrap = 0;
    tm_wrap = 0;
    ev_last = '0;
    tm_last = '0;
    ev_stamp_q.delete();
    time_ps_q.delete();
    for (int k = 0; k < (rx_q.size() - HDR_BYTES) / SAMPLE_LEN; k++) begin
      base = HDR_BYTES + SAMPLE_LEN * k;
      ev_raw = {rx_q[base], rx_q[base + 1], rx_q[base + 2], rx_q[base + 3]};
      tm_raw = {rx_q[base + 4], rx_q[base + 5], rx_q[base + 6], rx_q[base + 7]};
      // a drop against the previous sample means the counter wrapped
      if (k > 0 && ev_raw < ev_last) begin
        ev_wrap += 64'sh100000000;
      end
      if (k > 0 && tm_raw < tm_last) begin
        tm_wrap += 64'sh100000000;
      end
      ev_stamp_q.push_back(ev_wrap + longint'(ev_raw));
      time_ps_q.push_back((tm_wrap + longint'(tm_raw)) * TICK_PS -
                          longint'(rx_q[base + 8]) * INTERP_PS);
      ev_last = ev_raw;
      tm_last = tm_raw;
    end
  endtask : rebuild
  function automatic longint freq_hz(input int k);
    longint dt;
    dt = time_ps_q[k] - time_ps_q[k - 1];
    if (dt == 0) begin
      return 0;
    end
    return (ev_stamp_q[k] - ev_stamp_q[k - 1]) * PS_PER_S / dt;
  endfunction : freq_hz
endmodule : host_byte_sink
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DEPTH_T = 4;
  localparam longint TICK_PS = 2000;
  localparam longint INTERP_PS = 200;
  localparam longint PS_PER_S = 64'sd1000000000000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] chans = 3'h0;
  logic [1:0] src_sel = capture_pkg::SRC_A;
  logic armed = 1'b0;
  logic tb_tick = 1'b0;
  logic [7:0] interp_in = 8'h00;
  logic send_req = 1'b0;
  logic slow = 1'b0;
  logic byte_ready;
  logic [7:0] byte_data_ff;
  logic byte_valid_ff;
  logic busy_ff;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int ev_cnt = 0;
  int tick_cnt = 0;
  capture_pkg::sample_t exp_q[$];

  always #12.5 clk_sys = ~clk_sys;

  event_time_stamp_capture #(.DEPTH(DEPTH_T), .AW(2)) event_time_stamp_capture_inst (
    .clk_sys(clk_sys), .rst(rst), .chan_a(chans[0]), .chan_b(chans[1]), .chan_c(chans[2]),
    .src_sel(src_sel), .armed(armed), .tb_tick(tb_tick), .interp_in(interp_in),
    .send_req(send_req), .byte_ready(byte_ready), .byte_data_ff(byte_data_ff),
    .byte_valid_ff(byte_valid_ff), .busy_ff(busy_ff));

  host_byte_sink host_byte_sink_inst (.clk_sys(clk_sys), .byte_data(byte_data_ff),
    .byte_valid(byte_valid_ff), .slow(slow), .byte_ready(byte_ready));

  // ==========
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %0s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick();
    tb_tick <= 1'b1;
    cyc(2);
    tb_tick <= 1'b0;
    cyc(2);
    tick_cnt++;
  endtask : tick

  task automatic pulse(input int ch, input bit counted);
    chans[ch] <= 1'b1;
    cyc(2);
    chans[ch] <= 1'b0;
    cyc(2);
    if (counted) ev_cnt++;
  endtask : pulse

  // one timed event, then extra events that arrive while the tick is awaited
  task automatic timed(input int ch, input int extra);
    capture_pkg::sample_t s;
    interp_in <= 8'($urandom);
    cyc(1);
    pulse(ch, 1'b1);
    s.event_cnt = 32'(ev_cnt);
    repeat (extra) pulse(ch, 1'b1);
    cyc(2);
    tick();
    s.time_cnt = 32'(tick_cnt);
    s.interp = interp_in;
    if (exp_q.size() < DEPTH_T) exp_q.push_back(s);
    cyc(2);
  endtask : timed

  task automatic send_and_check(input string name);
    logic [7:0] exp_b[$];
    int len;
    int i;
    longint exp_t;
    longint last_t;
    longint exp_f;
    last_t = 0;
    len = exp_q.size() * capture_pkg::SAMPLE_BYTES;
    exp_b.push_back(capture_pkg::HDR_HASH);
    exp_b.push_back(capture_pkg::HDR_SIX);
    for (int d = 5; d >= 0; d--) begin
      exp_b.push_back(8'(capture_pkg::ASCII_ZERO + (len / 10**d) % 10));
    end
    foreach (exp_q[k]) begin
      for (int b = 8; b >= 0; b--) begin
        exp_b.push_back(exp_q[k][8*b +: 8]);
      end
    end
    send_req <= 1'b1;
    cyc(1);
    send_req <= 1'b0;
    i = 0;
    while (busy_ff !== 1'b1 && i < 20) begin
      cyc(1);
      i++;
    end
    i = 0;
    while (busy_ff !== 1'b0 && i < 5000) begin
      cyc(1);
      i++;
    end
    check(32'(host_byte_sink_inst.rx_q.size()), 32'(exp_b.size()), "byte count");
    foreach (exp_b[k]) begin
      if (k < host_byte_sink_inst.rx_q.size()) begin
        check(host_byte_sink_inst.rx_q[k], exp_b[k], "frame byte");
      end
    end
    host_byte_sink_inst.rebuild();
    foreach (exp_q[k]) begin
      exp_t = longint'(exp_q[k].time_cnt) * TICK_PS - longint'(exp_q[k].interp) * INTERP_PS;
      if (k < host_byte_sink_inst.ev_stamp_q.size()) begin
        check(32'(host_byte_sink_inst.ev_stamp_q[k]), exp_q[k].event_cnt, "event stamp");
        check(32'(host_byte_sink_inst.time_ps_q[k]), 32'(exp_t), "time stamp");
        if (k > 0 && exp_t != last_t) begin
          exp_f = longint'(exp_q[k].event_cnt - exp_q[k - 1].event_cnt) * PS_PER_S /
                  (exp_t - last_t);
          check(32'(host_byte_sink_inst.freq_hz(k)), 32'(exp_f), "frequency");
        end
      end
      last_t = exp_t;
    end
    host_byte_sink_inst.rx_q.delete();
    exp_q.delete();
    $display("test %0s done", name);
  endtask : send_and_check

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      $display("wrong value at %0t: run timed out", $time);
      summarize();
    end
  end

  // ==========
  // main sequence
  initial begin
    void'($urandom(32'hbba2));
    cyc(10);
    rst <= 1'b0;
    armed <= 1'b1;
    cyc(6);
    send_req <= 1'b1;
    cyc(1);
    send_req <= 1'b0;
    cyc(3);
    check(busy_ff, 1'b0, "send with empty memory");
    tick();
    tick();
    timed(0, 0);
    tick();
    timed(0, 0);
    timed(0, 0);
    send_and_check("chan_a");
    src_sel <= capture_pkg::SRC_B;
    slow <= 1'b1;
    cyc(2);
    pulse(0, 1'b0);
    timed(1, 0);
    pulse(0, 1'b0);
    timed(1, 0);
    send_and_check("chan_b_slow_sink");
    slow <= 1'b0;
    src_sel <= capture_pkg::SRC_A;
    armed <= 1'b0;
    cyc(6);
    pulse(0, 1'b0);
    pulse(0, 1'b0);
    armed <= 1'b1;
    cyc(6);
    timed(0, 0);
    send_and_check("arming");
    timed(0, 3);
    timed(0, 0);
    send_and_check("burst");
    src_sel <= capture_pkg::SRC_C;
    cyc(2);
    repeat (3) pulse(2, 1'b0);
    timed(2, 0);
    repeat (3) pulse(2, 1'b0);
    timed(2, 0);
    send_and_check("chan_c");
    src_sel <= 2'h3;
    cyc(2);
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    src_sel <= capture_pkg::SRC_A;
    cyc(2);
    repeat (DEPTH_T + 1) timed(0, 0);
    send_and_check("memory_full");
    timed(0, 0);
    send_and_check("after_full");
    summarize();
  end
endmodule : testbench
`default_nettype wire
